// File: common/pch_pkg.sv
// constants, register map and state type of the peripheral channel pair
// assumes a single 50 MHz clock domain shared by all users of the package
package pch_pkg;
    // ****************************************
    // widths
    // ****************************************
    localparam int PCH_AW = 8;
    localparam int PCH_DW = 32;
    localparam int PCH_CW = 16;
    localparam int PCH_NF = 4;
    // ****************************************
    // register offsets (byte addresses)
    // ****************************************
    localparam logic [7:0] PCH_RX_PTR = 8'h00;
    localparam logic [7:0] PCH_RX_CNT = 8'h04;
    localparam logic [7:0] PCH_TX_PTR = 8'h08;
    localparam logic [7:0] PCH_TX_CNT = 8'h0C;
    localparam logic [7:0] PCH_RX_NPTR = 8'h10;
    localparam logic [7:0] PCH_RX_NCNT = 8'h14;
    localparam logic [7:0] PCH_TX_NPTR = 8'h18;
    localparam logic [7:0] PCH_TX_NCNT = 8'h1C;
    localparam logic [7:0] PCH_CTRL = 8'h20;
    localparam logic [7:0] PCH_STATUS = 8'h24;
    localparam logic [7:0] PCH_IRQ_STAT = 8'h28;
    localparam logic [7:0] PCH_IRQ_MASK = 8'h2C;
    // ****************************************
    // field positions
    // ****************************************
    localparam int PCH_CTL_RX_EN = 0;
    localparam int PCH_CTL_TX_EN = 1;
    localparam int PCH_CTL_HALF = 2;
    localparam int PCH_F_END_RX = 0;
    localparam int PCH_F_END_TX = 1;
    localparam int PCH_F_RX_BUFF = 2;
    localparam int PCH_F_TX_BUFE = 3;
    localparam int PCH_ST_RX_RDY = 4;
    localparam int PCH_ST_TX_RDY = 5;
    // ****************************************
    // reset values and steps
    // ****************************************
    localparam logic [2:0] PCH_CTL_RST = 3'h0;
    localparam logic [3:0] PCH_FLAG_RST = 4'hF;
    localparam logic [3:0] PCH_MASK_RST = 4'h0;
    localparam logic [15:0] PCH_CNT_RST = 16'h0000;
    localparam logic [15:0] PCH_CNT_ONE = 16'h0001;
    localparam logic [31:0] PCH_PTR_RST = 32'h00000000;
    localparam logic [31:0] PCH_PTR_STEP = 32'h00000004;
    localparam logic [31:0] PCH_ZERO = 32'h00000000;
    // ****************************************
    // transfer sequencer states
    // ****************************************
    typedef enum logic [5:0] {
        PCH_IDLE = 6'h01,
        PCH_REQ = 6'h02,
        PCH_SRC = 6'h04,
        PCH_CAP = 6'h08,
        PCH_DST = 6'h10,
        PCH_DONE = 6'h20
    } pch_state_t;
endpackage : pch_pkg

// File: design/pch_channel_pair.sv
// receive and transmit channel pair moving words between a serial
// peripheral's holding registers and memory over the bus matrix
// assumes all inputs synchronous to ref_clk and bus_gnt held while bus_req
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
module pch_channel_pair (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [pch_pkg::PCH_AW-1:0] reg_addr,
    input wire logic [pch_pkg::PCH_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [pch_pkg::PCH_DW-1:0] reg_rdata,
    input wire logic rx_ready,
    input wire logic [pch_pkg::PCH_DW-1:0] per_rdata,
    output logic per_rd,
    input wire logic tx_ready,
    output logic per_wr,
    output logic [pch_pkg::PCH_DW-1:0] per_wdata,
    output logic bus_req,
    input wire logic bus_gnt,
    output logic [pch_pkg::PCH_DW-1:0] bus_addr,
    output logic bus_wr,
    output logic bus_rd,
    output logic [pch_pkg::PCH_DW-1:0] bus_wdata,
    input wire logic [pch_pkg::PCH_DW-1:0] bus_rdata,
    output logic irq
);
    import pch_pkg::*;

    function automatic logic hit(input logic [PCH_AW-1:0] a, input logic [PCH_AW-1:0] off);
        hit = (a == off);
    endfunction : hit

    // ****************************************
    // state
    // ****************************************
    pch_state_t st_r, st_nxt;
    logic dir_r, dir_nxt;
    logic [2:0] ctl_r;
    logic [31:0] rx_ptr_r, tx_ptr_r, rx_nptr_r, tx_nptr_r;
    logic [15:0] rx_cnt_r, tx_cnt_r, rx_ncnt_r, tx_ncnt_r;
    logic [PCH_NF-1:0] flags_r, ist_r, mask_r;
    logic [31:0] buf_r, bus_addr_r, reg_rdata_r;
    logic per_rd_r, per_wr_r, bus_req_r, bus_wr_r, bus_rd_r, irq_r;

    // ****************************************
    // register decode
    // ****************************************
    wire logic half = ctl_r[PCH_CTL_HALF];
    wire logic rx_en = ctl_r[PCH_CTL_RX_EN];
    wire logic tx_en = ctl_r[PCH_CTL_TX_EN];
    wire logic [15:0] wd16 = reg_wdata[PCH_CW-1:0];
    wire logic wd_nz = (wd16 != PCH_CNT_RST);
    wire logic wr_rcnt = reg_wr && hit(reg_addr, PCH_RX_CNT);
    wire logic wr_rncnt = reg_wr && hit(reg_addr, PCH_RX_NCNT);
    wire logic wr_tcnt = reg_wr && hit(reg_addr, PCH_TX_CNT);
    wire logic wr_tncnt = reg_wr && hit(reg_addr, PCH_TX_NCNT);
    // half duplex folds receive counter writes onto the shared counters
    wire logic rc_wr = wr_rcnt && !half;
    wire logic rnc_wr = wr_rncnt && !half;
    wire logic tc_wr = wr_tcnt || (half && wr_rcnt);
    wire logic tnc_wr = wr_tncnt || (half && wr_rncnt);
    wire logic [15:0] rx_cnt_v = half ? tx_cnt_r : rx_cnt_r;
    wire logic [15:0] rx_ncnt_v = half ? tx_ncnt_r : rx_ncnt_r;

    // ****************************************
    // transfer sequencer
    // ****************************************
    wire logic rx_go = rx_en && rx_ready && (rx_cnt_v != PCH_CNT_RST);
    wire logic tx_go = tx_en && tx_ready && (tx_cnt_r != PCH_CNT_RST);

    always_comb begin
        st_nxt = st_r;
        dir_nxt = dir_r;
        case (st_r)
            PCH_IDLE: begin
                if (rx_go) begin
                    st_nxt = PCH_REQ;
                    dir_nxt = 1'b0;
                end else if (tx_go) begin
                    st_nxt = PCH_REQ;
                    dir_nxt = 1'b1;
                end
            end
            PCH_REQ: begin
                if (bus_gnt) begin
                    st_nxt = PCH_SRC;
                end
            end
            PCH_SRC: st_nxt = PCH_CAP;
            PCH_CAP: st_nxt = PCH_DST;
            PCH_DST: st_nxt = PCH_DONE;
            PCH_DONE: st_nxt = PCH_IDLE;
            default: st_nxt = PCH_IDLE;
        endcase
    end

    wire logic in_bus = (st_nxt == PCH_REQ) || (st_nxt == PCH_SRC) ||
                        (st_nxt == PCH_CAP) || (st_nxt == PCH_DST);
    wire logic done_rx = (st_r == PCH_DONE) && !dir_r;
    wire logic done_tx = (st_r == PCH_DONE) && dir_r;
    wire logic [31:0] cap_data = dir_r ? bus_rdata : per_rdata;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= PCH_IDLE;
            dir_r <= 1'b0;
            buf_r <= PCH_ZERO;
            bus_addr_r <= PCH_ZERO;
            bus_req_r <= 1'b0;
            per_rd_r <= 1'b0;
            per_wr_r <= 1'b0;
            bus_rd_r <= 1'b0;
            bus_wr_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            dir_r <= dir_nxt;
            bus_req_r <= in_bus;
            bus_addr_r <= dir_nxt ? tx_ptr_r : rx_ptr_r;
            per_rd_r <= (st_nxt == PCH_SRC) && !dir_nxt;
            bus_rd_r <= (st_nxt == PCH_SRC) && dir_nxt;
            bus_wr_r <= (st_nxt == PCH_DST) && !dir_nxt;
            per_wr_r <= (st_nxt == PCH_DST) && dir_nxt;
            if (st_r == PCH_CAP) begin
                buf_r <= cap_data;
            end
        end
    end

    // ****************************************
    // counters and pointers
    // ****************************************
    wire logic [15:0] act_cnt = dir_r ? tx_cnt_r : rx_cnt_v;
    wire logic [15:0] act_ncnt = dir_r ? tx_ncnt_r : rx_ncnt_v;
    wire logic [15:0] cnt_dec = act_cnt - PCH_CNT_ONE;
    wire logic cnt_zero = (cnt_dec == PCH_CNT_RST);
    wire logic reload = cnt_zero && (act_ncnt != PCH_CNT_RST);
    wire logic [15:0] cnt_upd = reload ? act_ncnt : cnt_dec;
    wire logic rc_done = done_rx && !half;
    wire logic tc_done = done_tx || (half && done_rx);
    wire logic [15:0] rc_nxt = rc_wr ? wd16 : (rc_done ? cnt_upd : rx_cnt_r);
    wire logic [15:0] tc_nxt = tc_wr ? wd16 : (tc_done ? cnt_upd : tx_cnt_r);
    wire logic [15:0] rnc_nxt = rnc_wr ? wd16 : ((rc_done && reload) ? PCH_CNT_RST : rx_ncnt_r);
    wire logic [15:0] tnc_nxt = tnc_wr ? wd16 : ((tc_done && reload) ? PCH_CNT_RST : tx_ncnt_r);
    wire logic [31:0] rp_step = reload ? rx_nptr_r : (rx_ptr_r + PCH_PTR_STEP);
    wire logic [31:0] tp_step = reload ? tx_nptr_r : (tx_ptr_r + PCH_PTR_STEP);
    wire logic [31:0] rp_nxt = (reg_wr && hit(reg_addr, PCH_RX_PTR)) ? reg_wdata :
                               (done_rx ? rp_step : rx_ptr_r);
    wire logic [31:0] tp_nxt = (reg_wr && hit(reg_addr, PCH_TX_PTR)) ? reg_wdata :
                               (done_tx ? tp_step : tx_ptr_r);

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rx_cnt_r <= PCH_CNT_RST;
            tx_cnt_r <= PCH_CNT_RST;
            rx_ncnt_r <= PCH_CNT_RST;
            tx_ncnt_r <= PCH_CNT_RST;
            rx_ptr_r <= PCH_PTR_RST;
            tx_ptr_r <= PCH_PTR_RST;
            rx_nptr_r <= PCH_PTR_RST;
            tx_nptr_r <= PCH_PTR_RST;
            ctl_r <= PCH_CTL_RST;
            mask_r <= PCH_MASK_RST;
        end else begin
            rx_cnt_r <= rc_nxt;
            tx_cnt_r <= tc_nxt;
            rx_ncnt_r <= rnc_nxt;
            tx_ncnt_r <= tnc_nxt;
            rx_ptr_r <= rp_nxt;
            tx_ptr_r <= tp_nxt;
            if (reg_wr && hit(reg_addr, PCH_RX_NPTR)) begin
                rx_nptr_r <= reg_wdata;
            end
            if (reg_wr && hit(reg_addr, PCH_TX_NPTR)) begin
                tx_nptr_r <= reg_wdata;
            end
            if (reg_wr && hit(reg_addr, PCH_CTRL)) begin
                ctl_r <= reg_wdata[2:0];
            end
            if (reg_wr && hit(reg_addr, PCH_IRQ_MASK)) begin
                mask_r <= reg_wdata[PCH_NF-1:0];
            end
        end
    end

    // ****************************************
    // channel flags and interrupt
    // ****************************************
    wire logic clr_r = (wr_rcnt || wr_rncnt) && wd_nz;
    wire logic clr_t = (wr_tcnt || wr_tncnt) && wd_nz;
    wire logic last_zero = cnt_zero && (act_ncnt == PCH_CNT_RST);
    logic [PCH_NF-1:0] set_v, clr_v, ist_nxt;
    assign set_v[PCH_F_END_RX] = done_rx && cnt_zero;
    assign set_v[PCH_F_END_TX] = done_tx && cnt_zero;
    assign set_v[PCH_F_RX_BUFF] = done_rx && last_zero;
    assign set_v[PCH_F_TX_BUFE] = done_tx && last_zero;
    assign clr_v[PCH_F_END_RX] = clr_r;
    assign clr_v[PCH_F_END_TX] = clr_t;
    assign clr_v[PCH_F_RX_BUFF] = clr_t;
    assign clr_v[PCH_F_TX_BUFE] = clr_t;
    wire logic ist_wr = reg_wr && hit(reg_addr, PCH_IRQ_STAT);

    genvar gi;
    generate
        for (gi = 0; gi < PCH_NF; gi++) begin : g_flag
            assign ist_nxt[gi] = set_v[gi] || (ist_r[gi] && !(ist_wr && reg_wdata[gi]));
            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    flags_r[gi] <= PCH_FLAG_RST[gi];
                    ist_r[gi] <= 1'b0;
                end else begin
                    flags_r[gi] <= set_v[gi] || (flags_r[gi] && !clr_v[gi]);
                    ist_r[gi] <= ist_nxt[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(ist_nxt & mask_r);
        end
    end

    // ****************************************
    // register read
    // ****************************************
    wire logic [31:0] st_word = {26'h0000000, tx_ready, rx_ready, flags_r};
    wire logic [31:0] rd_val =
        hit(reg_addr, PCH_RX_PTR) ? rx_ptr_r :
        hit(reg_addr, PCH_RX_CNT) ? {16'h0000, rx_cnt_v} :
        hit(reg_addr, PCH_TX_PTR) ? tx_ptr_r :
        hit(reg_addr, PCH_TX_CNT) ? {16'h0000, tx_cnt_r} :
        hit(reg_addr, PCH_RX_NPTR) ? rx_nptr_r :
        hit(reg_addr, PCH_RX_NCNT) ? {16'h0000, rx_ncnt_v} :
        hit(reg_addr, PCH_TX_NPTR) ? tx_nptr_r :
        hit(reg_addr, PCH_TX_NCNT) ? {16'h0000, tx_ncnt_r} :
        hit(reg_addr, PCH_CTRL) ? {29'h00000000, ctl_r} :
        hit(reg_addr, PCH_STATUS) ? st_word :
        hit(reg_addr, PCH_IRQ_STAT) ? {28'h0000000, ist_r} :
        hit(reg_addr, PCH_IRQ_MASK) ? {28'h0000000, mask_r} : PCH_ZERO;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata_r <= PCH_ZERO;
        end else begin
            reg_rdata_r <= reg_rd ? rd_val : PCH_ZERO;
        end
    end

    assign reg_rdata = reg_rdata_r;
    assign per_rd = per_rd_r;
    assign per_wr = per_wr_r;
    assign per_wdata = buf_r;
    assign bus_req = bus_req_r;
    assign bus_addr = bus_addr_r;
    assign bus_wr = bus_wr_r;
    assign bus_rd = bus_rd_r;
    assign bus_wdata = buf_r;
    assign irq = irq_r;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence rx_move_s;
        per_rd_r ##2 (bus_wr_r && bus_wdata == $past(per_rdata));
    endsequence
    sequence tx_move_s;
        bus_rd_r ##2 (per_wr_r && per_wdata == $past(bus_rdata));
    endsequence

    start_gate_a: assert property ((st_r == PCH_IDLE) && (st_nxt == PCH_REQ) |->
        (dir_nxt ? (tx_en && tx_ready) : (rx_en && rx_ready)))
        else $error("transfer started without enable and ready");
    idle_hold_a: assert property ((st_r == PCH_IDLE) && !rx_en && !tx_en |=>
        (st_r == PCH_IDLE) && !bus_req_r)
        else $error("sequencer left idle while disabled");
    rx_request_a: assert property ((st_r == PCH_IDLE) && rx_go |=> bus_req_r && !dir_r)
        else $error("receive ready did not raise request");
    tx_request_a: assert property ((st_r == PCH_IDLE) && tx_go && !rx_go |=>
        bus_req_r && dir_r)
        else $error("transmit ready did not raise request");
    grant_wait_a: assert property ((st_r == PCH_REQ) && !bus_gnt |=>
        (st_r == PCH_REQ) && !per_rd_r && !bus_rd_r)
        else $error("transfer began before grant");
    strobe_req_a: assert property ((per_rd_r || per_wr_r || bus_rd_r || bus_wr_r) |->
        bus_req_r)
        else $error("transfer strobe outside bus request");
    rx_move_a: assert property (per_rd_r |-> rx_move_s)
        else $error("received word not written to memory");
    tx_move_a: assert property (bus_rd_r |-> tx_move_s)
        else $error("memory word not loaded to transmit register");
    status_ready_a: assert property (reg_rd && hit(reg_addr, PCH_STATUS) |=>
        (reg_rdata_r[PCH_ST_RX_RDY] == $past(rx_ready)) &&
        (reg_rdata_r[PCH_ST_TX_RDY] == $past(tx_ready)))
        else $error("ready levels not shown in status");
    end_rx_set_a: assert property (done_rx && (act_cnt == PCH_CNT_ONE) |=>
        flags_r[PCH_F_END_RX] && st_word[PCH_F_END_RX])
        else $error("receive end not set at zero");
    end_rx_clr_a: assert property (clr_r && !set_v[PCH_F_END_RX] |=>
        !flags_r[PCH_F_END_RX])
        else $error("receive end not cleared by count write");
    end_tx_set_a: assert property (done_tx && (act_cnt == PCH_CNT_ONE) |=>
        flags_r[PCH_F_END_TX])
        else $error("transmit end not set at zero");
    end_tx_a: assert property (clr_t && !set_v[PCH_F_END_TX] |=> !flags_r[PCH_F_END_TX])
        else $error("transmit end not cleared by count write");
    rx_buff_a: assert property (done_rx && last_zero |=> flags_r[PCH_F_RX_BUFF])
        else $error("receive full not set");
    tx_empty_set_a: assert property (done_tx && (act_cnt == PCH_CNT_ONE) &&
        (act_ncnt == PCH_CNT_RST) |=> flags_r[PCH_F_TX_BUFE])
        else $error("transmit empty not set");
    tx_bufe_a: assert property (clr_t && !set_v[PCH_F_TX_BUFE] && !set_v[PCH_F_RX_BUFF] |=>
        !flags_r[PCH_F_TX_BUFE] && !flags_r[PCH_F_RX_BUFF])
        else $error("buffer flags not cleared by transmit count write");
    tx_next_width_a: assert property (reg_rd && hit(reg_addr, PCH_TX_NCNT) |=>
        (reg_rdata_r[31:16] == 16'h0000))
        else $error("next transmit count shows upper bits");
    half_next_a: assert property (half && wr_rncnt |=> tx_ncnt_r == $past(wd16))
        else $error("half duplex next counts differ");
    count_step_a: assert property (tc_done && !tc_wr && !reload |=>
        tx_cnt_r == $past(tx_cnt_r) - PCH_CNT_ONE)
        else $error("counter did not decrement by one");
    reload_a: assert property (tc_done && !tc_wr && !tnc_wr && reload |=>
        (tx_cnt_r == $past(tx_ncnt_r)) && (tx_ncnt_r == PCH_CNT_RST))
        else $error("next count not reloaded");
endmodule : pch_channel_pair

// File: test/pch_far_model.sv
// behavioural serial peripheral, bus matrix and word memory facing the pair
// assumes the pair's registered strobes and one shared rising-edge clock
`timescale 1ns/100ps
module pch_far_model (
    input wire logic ref_clk,
    input wire logic resetn,
    output logic rx_ready,
    output logic [pch_pkg::PCH_DW-1:0] per_rdata,
    input wire logic per_rd,
    output logic tx_ready,
    input wire logic per_wr,
    input wire logic [pch_pkg::PCH_DW-1:0] per_wdata,
    input wire logic bus_req,
    output logic bus_gnt,
    input wire logic [pch_pkg::PCH_DW-1:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [pch_pkg::PCH_DW-1:0] bus_wdata,
    output logic [pch_pkg::PCH_DW-1:0] bus_rdata
);
    import pch_pkg::*;
    // ****************************************
    // state
    // ****************************************
    logic [31:0] mem [0:15];
    logic [31:0] transmit_holding_register [0:3];
    int rx_left = 0;
    int tx_space = 0;
    int rx_idx = 0;
    int thr_cnt = 0;
    int mem_wr_cnt = 0;
    int gwait = 0;
    logic slow = 1'b0;
    logic rd_d;
    // ****************************************
    // peripheral ready levels
    // ****************************************
    assign rx_ready = (rx_left != 0);
    assign tx_ready = (tx_space != 0);
    initial begin
        for (int i = 0; i < 16; i++) begin
            mem[i] = 32'h5A5A5A5A;
        end
    end
    // ****************************************
    // grant, holding registers and memory
    // ****************************************
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            bus_gnt <= 1'b0;
            gwait <= 0;
            rd_d <= 1'b0;
            per_rdata <= 32'hA0000000;
            bus_rdata <= PCH_ZERO;
        end else begin
            rd_d <= per_rd;
            if (!bus_req) begin
                bus_gnt <= 1'b0;
                gwait <= 0;
            end else begin
                gwait <= gwait + 1;
                if (!slow || gwait >= 3) begin
                    bus_gnt <= 1'b1;
                end
            end
            if (per_rd) begin
                rx_left <= rx_left - 1;
            end
            if (rd_d) begin
                rx_idx <= rx_idx + 1;
                per_rdata <= 32'hA0000000 + rx_idx + 1;
            end
            if (per_wr) begin
                transmit_holding_register[thr_cnt[1:0]] <= per_wdata;
                thr_cnt <= thr_cnt + 1;
                tx_space <= tx_space - 1;
            end
            if (bus_wr) begin
                mem[bus_addr[5:2]] <= bus_wdata;
                mem_wr_cnt <= mem_wr_cnt + 1;
            end
            bus_rdata <= bus_rd ? mem[bus_addr[5:2]] : ~bus_rdata;
        end
    end
endmodule : pch_far_model

// File: test/tb.sv
// self-checking bench for the peripheral channel pair
// assumes the far-side model above and the register map of the package
`timescale 1ns/100ps
module tb;
    import pch_pkg::*;
    // ****************************************
    // signals
    // ****************************************
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic [PCH_AW-1:0] reg_addr = 8'h00;
    logic [PCH_DW-1:0] reg_wdata = PCH_ZERO;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [PCH_DW-1:0] reg_rdata, per_rdata, per_wdata, bus_addr, bus_wdata, bus_rdata;
    logic rx_ready, per_rd, tx_ready, per_wr, bus_req, bus_gnt, bus_wr, bus_rd, irq;
    int fails = 0;
    int checks = 0;
    always #10 ref_clk = ~ref_clk;
    pch_channel_pair dut (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .rx_ready(rx_ready), .per_rdata(per_rdata), .per_rd(per_rd), .tx_ready(tx_ready),
        .per_wr(per_wr), .per_wdata(per_wdata), .bus_req(bus_req), .bus_gnt(bus_gnt),
        .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata), .irq(irq));
    pch_far_model u_far (.ref_clk(ref_clk), .resetn(resetn), .rx_ready(rx_ready),
        .per_rdata(per_rdata), .per_rd(per_rd), .tx_ready(tx_ready), .per_wr(per_wr),
        .per_wdata(per_wdata), .bus_req(bus_req), .bus_gnt(bus_gnt), .bus_addr(bus_addr),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata));
    // ****************************************
    // access and compare tasks
    // ****************************************
    task automatic tally_and_finish;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        chk(reg_rdata, exp);
    endtask : rchk
    task automatic ichk(input logic exp);
        repeat (2) @(posedge ref_clk);
        checks++;
        if (irq !== exp) begin
            fails++;
            $display("mismatch t=%0t got %h exp %h", $time, irq, exp);
        end
    endtask : ichk
    task automatic wait_for(input int which, input int n);
        int k = 0;
        while (((which == 0) ? u_far.mem_wr_cnt : u_far.thr_cnt) < n && k < 400) begin
            @(posedge ref_clk);
            k++;
        end
        if (k >= 400) begin
            fails++;
            $display("mismatch t=%0t got %h exp %h", $time, k, n);
            tally_and_finish();
        end else begin
            repeat (3) @(posedge ref_clk);
        end
    endtask : wait_for
    // ****************************************
    // tests
    // ****************************************
    initial begin
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        rchk(PCH_STATUS, 32'h0000000F);
        rchk(PCH_TX_NCNT, 32'h00000000);
        rchk(8'h30, 32'h00000000);
        $display("test reset done");
        wr(PCH_TX_NCNT, 32'hFFFFFFFF);
        rchk(PCH_TX_NCNT, 32'h0000FFFF);
        rchk(PCH_STATUS, 32'h00000001);
        wr(PCH_TX_NCNT, 32'h00000000);
        $display("test next count done");
        u_far.rx_left <= 3;
        wr(PCH_RX_PTR, 32'h00000000);
        wr(PCH_RX_CNT, 32'h00000002);
        wr(PCH_RX_NPTR, 32'h00000020);
        wr(PCH_RX_NCNT, 32'h00000001);
        wr(PCH_IRQ_MASK, 32'h00000005);
        rchk(PCH_STATUS, 32'h00000010);
        repeat (20) @(posedge ref_clk);
        chk(u_far.mem[0], 32'h5A5A5A5A);
        wr(PCH_CTRL, 32'h00000001);
        wait_for(0, 3);
        chk(u_far.mem[0], 32'hA0000000);
        chk(u_far.mem[1], 32'hA0000001);
        chk(u_far.mem[8], 32'hA0000002);
        rchk(PCH_RX_CNT, 32'h00000000);
        rchk(PCH_RX_NCNT, 32'h00000000);
        rchk(PCH_STATUS, 32'h00000005);
        rchk(PCH_IRQ_STAT, 32'h00000005);
        ichk(1'b1);
        wr(PCH_IRQ_STAT, 32'h00000005);
        ichk(1'b0);
        $display("test receive done");
        u_far.mem[4] <= 32'h11111111;
        u_far.mem[5] <= 32'h22222222;
        u_far.slow <= 1'b1;
        u_far.tx_space <= 2;
        wr(PCH_TX_PTR, 32'h00000010);
        wr(PCH_TX_CNT, 32'h00000002);
        wr(PCH_CTRL, 32'h00000002);
        wait_for(1, 2);
        chk(u_far.transmit_holding_register[0], 32'h11111111);
        chk(u_far.transmit_holding_register[1], 32'h22222222);
        rchk(PCH_STATUS, 32'h0000000B);
        rchk(PCH_IRQ_STAT, 32'h0000000A);
        ichk(1'b0);
        wr(PCH_IRQ_MASK, 32'h0000000F);
        ichk(1'b1);
        $display("test transmit done");
        wr(PCH_CTRL, 32'h00000004);
        wr(PCH_TX_NCNT, 32'h00000003);
        rchk(PCH_RX_NCNT, 32'h00000003);
        wr(PCH_RX_CNT, 32'h00000005);
        rchk(PCH_TX_CNT, 32'h00000005);
        u_far.rx_left <= 1;
        wr(PCH_CTRL, 32'h00000005);
        wait_for(0, 4);
        chk(u_far.mem[9], 32'hA0000003);
        rchk(PCH_TX_CNT, 32'h00000004);
        rchk(PCH_RX_CNT, 32'h00000004);
        $display("test half duplex done");
        tally_and_finish();
    end
endmodule : tb
